// ---- rtl/sosc_pkg.sv ----
// Constants for the standby and oscillator settle controller.
// Assumes an 8-bit register port on the core side and one system clock.
package sosc_pkg;
  // ==========================================================================
  // Register map.
  localparam logic [15:0] SETTLE_STATUS_ADDR = 16'hffa3; // Status, read only.
  localparam logic [15:0] SETTLE_SELECT_ADDR = 16'hffa4; // Wait select, read/write.
  localparam logic [7:0] SETTLE_STATUS_RST = 8'h00; // Status after reset.
  localparam logic [7:0] SETTLE_SELECT_RST = 8'h05; // Select after reset.
  localparam logic [2:0] SEL_MASK = 3'h7; // Select field width mask.
  localparam int MAIN_OSC_HALT_BIT = 7; // Main oscillator stop bit position.
  // ==========================================================================
  // Stage counts in crystal cycles.
  localparam int STAGE_W = 17; // Counter width, enough for 2^16.
  localparam logic [16:0] STAGE0_CNT = 17'h00800; // 2^11.
  localparam logic [16:0] STAGE1_CNT = 17'h02000; // 2^13.
  localparam logic [16:0] STAGE2_CNT = 17'h04000; // 2^14.
  localparam logic [16:0] STAGE3_CNT = 17'h08000; // 2^15.
  localparam logic [16:0] STAGE4_CNT = 17'h10000; // 2^16.
  // ==========================================================================
  // Halt release wait in core clocks.
  localparam logic [3:0] WAKE_VECTOR_CLKS = 4'h8; // Vectored interrupt.
  localparam logic [3:0] WAKE_NEXT_CLKS = 4'h2; // Next instruction.
  // Power states.
  typedef enum logic [1:0] {
    SOSC_RUN = 2'b00,
    SOSC_HALT = 2'b01,
    SOSC_STOP = 2'b10,
    SOSC_WAKE = 2'b11
  } sosc_state_e;
endpackage

// ---- rtl/sosc_ctrl.sv ----
// Standby controller: halt and stop states, crystal settle counter.
// Assumes crystal_tick_i is a level from the crystal clock domain, synchronised here.
`timescale 1ns/1ps
// Operation
// - Halt gates core clock, oscillators keep running.
// - Stop shuts crystal and internal oscillators.
// - Low-power states keep all state intact, except that entering stop clears the settle counter and status.
// - Stop only on main clock; halt any.
// - Subsystem oscillator never stopped by stop.
// - Interrupt request releases stop state.
// - Status clears on reset, stop, oscillator halt.
// - Status read only, bits 7..5 zero.
// - Stage flags set in order and stick.
// - Counter stops at selected wait length.
// - Select codes 1..5 map to stages.
// - Select resets 05, byte write, top zero.
// - Crystal core clock held after stop until wait ends, for select codes 1..5.
// - Count only after oscillation has started.
// - Halt wake waits 8 or 2 clocks.
// - Reset releases halt to reset vector.
module sosc_ctrl (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic halt_req_i, // Halt instruction pulse.
  input wire logic stop_req_i, // Stop instruction pulse.
  input wire logic on_main_clk_i, // Core runs from main system clock.
  input wire logic on_crystal_i, // Core clock is the crystal clock.
  input wire logic irq_i, // Unmasked interrupt request level.
  input wire logic irq_vectored_i, // Interrupt will be vectored.
  input wire logic crystal_tick_i, // Crystal clock sampled as a level.
  input wire logic crystal_running_i, // Crystal oscillation has started.
  input wire logic [15:0] addr_i, // Register address.
  input wire logic wr_i, // Byte write strobe.
  input wire logic [7:0] wdata_i, // Write data.
  input wire logic osc_ctl_wr_i, // Write to the oscillator control register.
  output logic [7:0] rdata_o, // Read data.
  output logic core_clk_en_o, // Core clock enable.
  output logic crystal_en_o, // Crystal oscillator enable.
  output logic int_osc_en_o, // Internal high-speed oscillator enable.
  output logic sub_osc_en_o, // Subsystem oscillator enable.
  output logic [1:0] state_o // Current power state.
);
  // ==========================================================================
  // Helpers.
  // Map select code to the number of stage flags it allows.
  function automatic logic [2:0] sel_stages(input logic [2:0] sel);
    logic [2:0] n;
    n = 3'h0;
    if (sel >= 3'h1 && sel <= 3'h5) begin
      n = sel;
    end
    return n;
  endfunction

  // Tell whether the flag of the selected stage is set; prohibited codes never finish.
  function automatic logic stage_done(input logic [4:0] flags, input logic [2:0] n);
    logic done;
    case (n)
      3'h1: done = flags[4];
      3'h2: done = flags[3];
      3'h3: done = flags[2];
      3'h4: done = flags[1];
      3'h5: done = flags[0];
      default: done = 1'b0;
    endcase
    return done;
  endfunction

  // ==========================================================================
  // Input synchronisers for crystal-domain levels.
  logic tick_s1_q, tick_s2_q, tick_s3_q; // Tick sync chain and edge history.
  logic run_s1_q, run_s2_q; // Oscillation-started sync.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
      run_s1_q <= 1'b0;
      run_s2_q <= 1'b0;
    end else begin
      tick_s1_q <= crystal_tick_i;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
      run_s1_q <= crystal_running_i;
      run_s2_q <= run_s1_q;
    end
  end
  logic xtal_edge; // One crystal cycle seen.
  assign xtal_edge = tick_s2_q & ~tick_s3_q;

  // ==========================================================================
  // State machine and registers.
  sosc_pkg::sosc_state_e state_q, state_d; // Power state.
  logic [2:0] sel_q, sel_d; // Wait select field.
  logic [4:0] flags_q, flags_d; // Stage flags, bit 4 first.
  logic [16:0] cnt_q, cnt_d; // Settle counter.
  logic [3:0] wake_q, wake_d; // Halt wake countdown.
  logic [7:0] rdata_q, rdata_d; // Read data.
  logic stop_ok; // Stop request accepted.
  logic clr_status; // Status clear cause.
  logic [2:0] n_stages; // Allowed stages.
  logic sel_done; // Flag of the selected stage is set.
  logic stop_wake_q, stop_wake_d; // Current wake started from stop, so settle may hold it.

  // Next-state and register logic.
  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    flags_d = flags_q;
    cnt_d = cnt_q;
    wake_d = wake_q;
    stop_wake_d = stop_wake_q;
    n_stages = sel_stages(sel_q);
    sel_done = stage_done(flags_q, n_stages);
    stop_ok = stop_req_i & on_main_clk_i & (state_q == sosc_pkg::SOSC_RUN);
    clr_status = stop_ok | (osc_ctl_wr_i & wdata_i[sosc_pkg::MAIN_OSC_HALT_BIT]);
    if (wr_i && addr_i == sosc_pkg::SETTLE_SELECT_ADDR) begin
      sel_d = wdata_i[2:0] & sosc_pkg::SEL_MASK;
    end
    if (clr_status) begin
      cnt_d = 17'h00000;
      flags_d = 5'h00;
    end else if (xtal_edge && run_s2_q && n_stages != 3'h0 && !sel_done) begin
      cnt_d = cnt_q + 17'h00001;
      if (cnt_d >= sosc_pkg::STAGE0_CNT) flags_d[4] = 1'b1;
      if (cnt_d >= sosc_pkg::STAGE1_CNT && n_stages > 3'h1) flags_d[3] = 1'b1;
      if (cnt_d >= sosc_pkg::STAGE2_CNT && n_stages > 3'h2) flags_d[2] = 1'b1;
      if (cnt_d >= sosc_pkg::STAGE3_CNT && n_stages > 3'h3) flags_d[1] = 1'b1;
      if (cnt_d >= sosc_pkg::STAGE4_CNT && n_stages > 3'h4) flags_d[0] = 1'b1;
    end
    case (state_q)
      sosc_pkg::SOSC_RUN: begin
        if (stop_ok) begin
          state_d = sosc_pkg::SOSC_STOP;
        end else if (halt_req_i) begin
          state_d = sosc_pkg::SOSC_HALT;
        end
      end
      sosc_pkg::SOSC_HALT: begin
        if (irq_i) begin
          state_d = sosc_pkg::SOSC_WAKE;
          wake_d = irq_vectored_i ? sosc_pkg::WAKE_VECTOR_CLKS : sosc_pkg::WAKE_NEXT_CLKS;
          // A halt wake never waits for the settle counter.
          stop_wake_d = 1'b0;
        end
      end
      sosc_pkg::SOSC_STOP: begin
        if (irq_i) begin
          state_d = sosc_pkg::SOSC_WAKE;
          wake_d = 4'h1;
          // Remember that the crystal was stopped and must settle again.
          stop_wake_d = 1'b1;
        end
      end
      sosc_pkg::SOSC_WAKE: begin
        if (wake_q > 4'h1) begin
          wake_d = wake_q - 4'h1;
        end else if (!stop_wake_q || !on_crystal_i || n_stages == 3'h0 || sel_done) begin
          state_d = sosc_pkg::SOSC_RUN;
          wake_d = 4'h0;
          stop_wake_d = 1'b0;
        end
      end
      default: state_d = sosc_pkg::SOSC_RUN;
    endcase
    if (addr_i == sosc_pkg::SETTLE_STATUS_ADDR) begin
      rdata_d = {3'h0, flags_d};
    end else if (addr_i == sosc_pkg::SETTLE_SELECT_ADDR) begin
      rdata_d = {5'h00, sel_d};
    end else begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= sosc_pkg::SOSC_RUN;
      sel_q <= sosc_pkg::SETTLE_SELECT_RST[2:0];
      flags_q <= sosc_pkg::SETTLE_STATUS_RST[4:0];
      cnt_q <= 17'h00000;
      wake_q <= 4'h0;
      stop_wake_q <= 1'b0;
      rdata_q <= 8'h00;
      core_clk_en_o <= 1'b1;
      crystal_en_o <= 1'b1;
      int_osc_en_o <= 1'b1;
      sub_osc_en_o <= 1'b1;
      state_o <= 2'b00;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      flags_q <= flags_d;
      cnt_q <= cnt_d;
      wake_q <= wake_d;
      stop_wake_q <= stop_wake_d;
      rdata_q <= rdata_d;
      core_clk_en_o <= (state_d == sosc_pkg::SOSC_RUN);
      crystal_en_o <= (state_d != sosc_pkg::SOSC_STOP);
      int_osc_en_o <= (state_d != sosc_pkg::SOSC_STOP);
      sub_osc_en_o <= 1'b1;
      state_o <= state_d;
    end
  end
  // stop entry clears the settle counter and stage flags
  assign rdata_o = rdata_q;

  // ==========================================================================
  // Checks.
  halt_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_o == 2'b01 |-> !core_clk_en_o && crystal_en_o)
    else $error("halt does not gate core only");
  stop_osc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_o == 2'b10 |-> !crystal_en_o && !int_osc_en_o)
    else $error("stop leaves oscillators on");
  sub_osc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_o == 2'b10 |-> sub_osc_en_o)
    else $error("subsystem oscillator stopped");
  stop_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == sosc_pkg::SOSC_RUN && stop_req_i && !on_main_clk_i && !halt_req_i
    |=> state_q == sosc_pkg::SOSC_RUN)
    else $error("stop taken off main clock");
  status_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_ok |=> flags_q == 5'h00)
    else $error("status not cleared by stop");
  status_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
    addr_i == sosc_pkg::SETTLE_STATUS_ADDR |=> rdata_o[7:5] == 3'h0)
    else $error("status top bits not zero");
  flag_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    flags_q[3] |-> flags_q[4])
    else $error("stage flags out of order");
  stop_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == sosc_pkg::SOSC_STOP && irq_i |=> state_q == sosc_pkg::SOSC_WAKE)
    else $error("interrupt did not release stop");
  halt_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == sosc_pkg::SOSC_HALT && irq_i && !irq_vectored_i
    |=> state_q == sosc_pkg::SOSC_WAKE ##1 state_q == sosc_pkg::SOSC_WAKE)
    else $error("halt wake too short");
  wake_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == sosc_pkg::SOSC_WAKE && stop_wake_q && wake_q == 4'h1 && on_crystal_i &&
    n_stages != 3'h0 && !sel_done |=> state_q == sosc_pkg::SOSC_WAKE)
    else $error("core released before settle");
endmodule

// ---- test/sosc_core_model.sv ----
// Behavioural processor core that issues halt and stop instructions and interrupts.
// Assumes the bench calls its tasks from one process; outputs change just after clk_i rises.
`timescale 1ns/1ps
module sosc_core_model (
  input wire logic clk_i, // System clock.
  output logic halt_req_o, // Halt instruction pulse.
  output logic stop_req_o, // Stop instruction pulse.
  output logic on_main_clk_o, // Core runs from the main clock.
  output logic on_crystal_o, // Core clock is the crystal.
  output logic irq_o, // Unmasked interrupt level.
  output logic irq_vectored_o // Interrupt will be vectored.
);
  // ==========================================================================
  // Idle core on the main clock at time zero.
  initial begin
    halt_req_o = 1'b0;
    stop_req_o = 1'b0;
    on_main_clk_o = 1'b1;
    on_crystal_o = 1'b0;
    irq_o = 1'b0;
    irq_vectored_o = 1'b0;
  end
  // Selects the clock source and the interrupt acceptance mode.
  task automatic mode(input logic main, input logic xtal, input logic vec);
    @(posedge clk_i);
    on_main_clk_o <= main;
    on_crystal_o <= xtal;
    irq_vectored_o <= vec;
  endtask
  // status polled by the bench.
  // Issues one instruction as a one-cycle pulse.
  task automatic instr(input logic is_stop);
    @(posedge clk_i);
    if (is_stop) begin
      stop_req_o <= 1'b1;
    end else begin
      halt_req_o <= 1'b1;
    end
    @(posedge clk_i);
    stop_req_o <= 1'b0;
    halt_req_o <= 1'b0;
  endtask
  // Raises or drops the interrupt request level.
  task automatic irq(input logic lvl);
    @(posedge clk_i);
    irq_o <= lvl;
  endtask
endmodule

// ---- test/standby_osc_stabilization_test.sv ----
// Self-checking bench for the standby controller and its settle counter.
// Assumes a 200 MHz clock and a crystal tick slow enough for the two-flop sync.
`timescale 1ns/1ps
module standby_osc_stabilization_test;
  logic clk_i = 1'b0; // System clock.
  logic rst_i; // Synchronous reset.
  logic xtal; // Crystal as a level.
  logic xrun; // Crystal oscillating.
  logic wr; // Register write strobe.
  logic oscw; // Oscillator control write.
  logic [15:0] addr; // Register address.
  logic [7:0] wdata; // Write data.
  logic [7:0] rdata; // Read data.
  logic cke, xen, ien, sen; // Clock and oscillator enables.
  logic [1:0] st; // Power state.
  logic hr, sr, om, oc, iq, iv; // Core model outputs.
  int miscompares = 0; // Mismatch count.
  int tests_run = 0; // Comparison count.
  int cyc = 0; // Cycle count for the timeout.
  int n; // Wait length.
  // ==========================================================================
  // Clocks and timeout; crystal rises every four cycles.
  always #2.5 clk_i = ~clk_i;
  always begin
    repeat (2) @(posedge clk_i);
    xtal <= ~xtal;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 70000) begin
      miscompares++;
      final_report();
    end
  end
  sosc_core_model core_u (.clk_i(clk_i), .halt_req_o(hr), .stop_req_o(sr), .on_main_clk_o(om),
    .on_crystal_o(oc), .irq_o(iq), .irq_vectored_o(iv));
  sosc_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .halt_req_i(hr), .stop_req_i(sr),
    .on_main_clk_i(om), .on_crystal_i(oc), .irq_i(iq), .irq_vectored_i(iv),
    .crystal_tick_i(xtal), .crystal_running_i(xrun), .addr_i(addr), .wr_i(wr),
    .wdata_i(wdata), .osc_ctl_wr_i(oscw), .rdata_o(rdata), .core_clk_en_o(cke),
    .crystal_en_o(xen), .int_osc_en_o(ien), .sub_osc_en_o(sen), .state_o(st));
  // ==========================================================================
  // Access tasks and the comparison.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr <= a;
    @(posedge clk_i);
    #1 check(rdata, exp);
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d, input logic osc);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= ~osc;
    oscw <= osc;
    @(posedge clk_i);
    wr <= 1'b0;
    oscw <= 1'b0;
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Main sequence.
  initial begin
    rst_i <= 1'b1;
    xtal <= 1'b0;
    xrun <= 1'b1;
    wr <= 1'b0;
    oscw <= 1'b0;
    addr <= 16'h0000;
    wdata <= 8'h00;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(16'hffa3, 8'h00);
    rd(16'hffa4, 8'h05);
    wr_reg(16'hffa4, 8'hff, 1'b0);
    rd(16'hffa4, 8'h07);
    wr_reg(16'hffa3, 8'hff, 1'b0);
    rd(16'hffa3, 8'h00);
    // Halt release by plain and by vectored interrupt.
    for (int v = 0; v < 2; v++) begin
      core_u.mode(1'b1, 1'b0, v[0]);
      core_u.instr(1'b0);
      #1 check({cke, xen, ien, sen, 2'b00, st}, 8'h71);
      core_u.irq(1'b1);
      n = 0;
      do begin
        @(posedge clk_i);
        #1 n++;
      end while (st !== 2'b00 && n < 50);
      check(8'(n), v ? 8'h09 : 8'h03);
      core_u.irq(1'b0);
    end
    // Stop refused off the main clock, halt accepted, reset releases it.
    core_u.mode(1'b0, 1'b0, 1'b0);
    core_u.instr(1'b1);
    #1 check(8'(st), 8'h00);
    core_u.instr(1'b0);
    #1 check(8'(st), 8'h01);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    #1 check({cke, 5'h00, st}, 8'h80);
    core_u.mode(1'b1, 1'b1, 1'b0);
    wr_reg(16'hffa4, 8'h01, 1'b0);
    xrun <= 1'b0;
    core_u.instr(1'b1);
    #1 check({xen, ien, sen, 3'h0, st}, 8'h22);
    rd(16'hffa3, 8'h00);
    core_u.irq(1'b1);
    repeat (1000) @(posedge clk_i);
    #1 check({cke, 5'h00, st}, 8'h03);
    xrun <= 1'b1;
    n = 0;
    while (st !== 2'b00 && n < 20000) begin
      @(posedge clk_i);
      #1 n++;
    end
    check(8'(n > 8000 && n < 8400), 8'h01);
    core_u.irq(1'b0);
    rd(16'hffa3, 8'h10);
    wr_reg(16'h0000, 8'h00, 1'b1);
    rd(16'hffa3, 8'h10);
    wr_reg(16'h0000, 8'h80, 1'b1);
    rd(16'hffa3, 8'h00);
    // select changed while a wait runs, then a clear restarts counting.
    wr_reg(16'hffa4, 8'h02, 1'b0);
    wr_reg(16'h0000, 8'h80, 1'b1);
    repeat (9000) @(posedge clk_i);
    rd(16'hffa3, 8'h10);
    repeat (24200) @(posedge clk_i);
    rd(16'hffa3, 8'h18);
    wr_reg(16'hffa4, 8'h00, 1'b0);
    wr_reg(16'h0000, 8'h80, 1'b1);
    repeat (9000) @(posedge clk_i);
    rd(16'hffa3, 8'h00);
    final_report();
  end
endmodule
